/* File: design/phy_csr_pkg.sv */
// Shared constants and types for the physical-layer reset and register bank.
// Assumes a 125 MHz management clock and a word-addressed management port.
package phy_csr_pkg;

  // ************************************************************
  // Bus geometry
  // ************************************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // ************************************************************
  // Word offsets of the physical-layer registers
  // ************************************************************
  localparam logic [ADDR_W-1:0] OFS_REVISION   = 12'h300;
  localparam logic [ADDR_W-1:0] OFS_SCRATCH    = 12'h301;
  localparam logic [ADDR_W-1:0] OFS_VARIANT0   = 12'h302;
  localparam logic [ADDR_W-1:0] OFS_VARIANT1   = 12'h303;
  localparam logic [ADDR_W-1:0] OFS_VARIANT2   = 12'h304;
  localparam logic [ADDR_W-1:0] OFS_CONTROL    = 12'h310;
  localparam logic [ADDR_W-1:0] OFS_BLOCK_LOCK = 12'h312;
  localparam logic [ADDR_W-1:0] OFS_LOOPBACK   = 12'h313;
  localparam logic [ADDR_W-1:0] OFS_FLAG_SEL   = 12'h314;
  localparam logic [ADDR_W-1:0] OFS_FLAG_READ  = 12'h315;

  // ************************************************************
  // Fields of the reset and clock-recovery control register
  // ************************************************************
  localparam int CTL_SYS_RST    = 0;
  localparam int CTL_TX_SOFT    = 1;
  localparam int CTL_RX_SOFT    = 2;
  localparam int CTL_LOCK_REF   = 4;
  localparam int CTL_LOCK_DATA  = 5;
  localparam logic [5:0] CTL_WRITE_MASK = 6'h37;
  localparam logic [5:0] CTL_RESET      = 6'h00;
  localparam logic [31:0] SCRATCH_RESET = 32'h00000000;
  localparam logic [2:0] FLAG_SEL_RESET = 3'h0;
  localparam int FLAG_SEL_W = 3;
  localparam int FLAGS_PER_LANE = 8;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_PS = 8000;
  localparam int SYNC_STAGES   = 3;
  localparam int SETTLE_NS     = 80;
  localparam int SETTLE_CYCLES = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ************************************************************
  // Address windows
  // ************************************************************
  typedef enum logic [3:0] {
    WIN_NONE  = 4'h0,
    WIN_PHY   = 4'h1,
    WIN_TXMAC = 4'h2,
    WIN_RXMAC = 4'h3,
    WIN_FLOW  = 4'h4,
    WIN_STATT = 4'h5,
    WIN_STATR = 4'h6,
    WIN_TSTX  = 4'h7,
    WIN_TSRX  = 4'h8,
    WIN_FECTX = 4'h9,
    WIN_FECRX = 4'hA
  } window_t;

  typedef enum logic [2:0] {
    SEQ_HOLD   = 3'h1,
    SEQ_SETTLE = 3'h2,
    SEQ_READY  = 3'h4
  } seq_state_t;

  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mgmt_req_t;

endpackage

/* File: design/pin_sync.sv */
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes the synchronous reset is held long enough to flush all stages.
`timescale 1ns/1ps
module pin_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] level_o
);
  logic [W-1:0] s1_reg, s2_reg, s3_reg, q_reg, q_next;

  // ************************************************************
  // Filter: a change counts only when stages two and three agree
  // ************************************************************
  always_comb begin
    q_next = q_reg;
    for (int i = 0; i < W; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        q_next[i] = s3_reg[i];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
      q_reg  <= RST_VAL;
    end else begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg  <= q_next;
    end
  end

  assign level_o = q_reg;
endmodule // pin_sync

/* File: design/path_reset_seq.sv */
// Reset sequencer for one datapath direction: hold, settle, ready.
// Assumes hold_i and ok_i are already in the management clock domain.
`timescale 1ns/1ps
module path_reset_seq #(
  parameter int SETTLE = phy_csr_pkg::SETTLE_CYCLES
) (
  input  wire logic mclk_i,
  input  wire logic rst_i,
  input  wire logic hold_i,
  input  wire logic ok_i,
  output logic      logic_rst_o,
  output logic      ready_o
);
  phy_csr_pkg::seq_state_t state_reg, state_next;
  logic [15:0]             cnt_reg, cnt_next;

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      phy_csr_pkg::SEQ_HOLD: begin
        cnt_next = 16'h0000;
        if (!hold_i) state_next = phy_csr_pkg::SEQ_SETTLE;
      end
      phy_csr_pkg::SEQ_SETTLE: begin
        if (hold_i) begin
          state_next = phy_csr_pkg::SEQ_HOLD;
        end else if (cnt_reg >= 16'(SETTLE - 1) && ok_i) begin
          state_next = phy_csr_pkg::SEQ_READY;
        end else if (cnt_reg < 16'(SETTLE - 1)) begin
          cnt_next = cnt_reg + 16'h0001;
        end
      end
      phy_csr_pkg::SEQ_READY: begin
        // Losing the health condition drops ready without resetting logic.
        if (hold_i) state_next = phy_csr_pkg::SEQ_HOLD;
        else if (!ok_i) state_next = phy_csr_pkg::SEQ_SETTLE;
      end
      default: state_next = phy_csr_pkg::SEQ_HOLD;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_reg <= phy_csr_pkg::SEQ_HOLD;
      cnt_reg   <= 16'h0000;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  assign logic_rst_o = (state_reg == phy_csr_pkg::SEQ_HOLD);
  assign ready_o     = (state_reg == phy_csr_pkg::SEQ_READY);
endmodule // path_reset_seq

/* File: design/phy_reset_csr_bank.sv */
// Reset handling and physical-layer register bank of a 25G Ethernet core.
// Assumes a word-addressed management port on mclk_i and asynchronous pins.
`timescale 1ns/1ps

module phy_reset_csr_bank #(
  parameter int          LANES    = 1,
  parameter logic [31:0] REVISION = 32'h00010000, // Arbitrary value.
  parameter logic [31:0] VARIANT0 = 32'h00004142, // Arbitrary value.
  parameter logic [31:0] VARIANT1 = 32'h00004344, // Arbitrary value.
  parameter logic [31:0] VARIANT2 = 32'h00454647  // Arbitrary value.
) (
  input  wire logic                                   mclk_i,
  input  wire logic                                   rst_i,
  input  wire logic                                   csr_rst_n_i,
  input  wire logic                                   tx_rst_n_i,
  input  wire logic                                   rx_rst_n_i,
  input  wire logic [phy_csr_pkg::ADDR_W-1:0]         mgmt_address_i,
  input  wire logic                                   mgmt_read_i,
  input  wire logic                                   mgmt_write_i,
  input  wire logic [phy_csr_pkg::DATA_W-1:0]         mgmt_writedata_i,
  output logic      [phy_csr_pkg::DATA_W-1:0]         mgmt_readdata_o,
  output logic                                        mgmt_readdatavalid_o,
  input  wire logic [LANES-1:0]                       block_lock_i,
  input  wire logic [LANES*phy_csr_pkg::FLAGS_PER_LANE-1:0] fifo_flags_i,
  output logic                                        tx_pcs_rst_o,
  output logic                                        rx_pcs_rst_o,
  output logic                                        xcvr_rst_o,
  output logic                                        cdr_lock_to_ref_o,
  output logic                                        cdr_lock_to_data_o,
  output logic      [LANES-1:0]                       serial_loopback_o,
  output logic                                        rx_block_lock_o,
  output logic                                        tx_lanes_stable_o,
  output logic                                        rx_pcs_ready_o
);

  localparam int FW = LANES * phy_csr_pkg::FLAGS_PER_LANE;

  // ************************************************************
  // Window decode
  // ************************************************************
  function automatic phy_csr_pkg::window_t win_of(input logic [phy_csr_pkg::ADDR_W-1:0] a);
    phy_csr_pkg::window_t w;
    w = phy_csr_pkg::WIN_NONE;
    if (a[11:8] == 4'h3) w = phy_csr_pkg::WIN_PHY;
    else if (a[11:8] == 4'h4) w = phy_csr_pkg::WIN_TXMAC;
    else if (a[11:8] == 4'h5) w = phy_csr_pkg::WIN_RXMAC;
    else if (a >= 12'h600 && a <= 12'h708) w = phy_csr_pkg::WIN_FLOW;
    else if (a[11:8] == 4'h8) w = phy_csr_pkg::WIN_STATT;
    else if (a[11:8] == 4'h9) w = phy_csr_pkg::WIN_STATR;
    else if (a[11:8] == 4'hA) w = phy_csr_pkg::WIN_TSTX;
    else if (a[11:8] == 4'hB) w = phy_csr_pkg::WIN_TSRX;
    else if (a[11:8] == 4'hC) w = phy_csr_pkg::WIN_FECTX;
    else if (a[11:8] == 4'hD) w = phy_csr_pkg::WIN_FECRX;
    return w;
  endfunction

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [2:0]       rst_pins_sync;
  logic [LANES-1:0] lock_sync;
  logic [FW-1:0]    flags_sync;

  pin_sync #(.W(3), .RST_VAL(3'h0)) u_rst_sync (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .pin_i   ({csr_rst_n_i, tx_rst_n_i, rx_rst_n_i}),
    .level_o (rst_pins_sync)
  );

  // Lock and FIFO flags come from the transceiver clock, so they are
  // synchronised too; the readout is therefore a few cycles stale.
  pin_sync #(.W(LANES + FW), .RST_VAL('0)) u_stat_sync (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .pin_i   ({block_lock_i, fifo_flags_i}),
    .level_o ({lock_sync, flags_sync})
  );

  logic glob_rst;
  assign glob_rst = rst_i | ~rst_pins_sync[2];

  // ************************************************************
  // Register file
  // ************************************************************
  phy_csr_pkg::mgmt_req_t req;
  assign req = '{rd: mgmt_read_i, wr: mgmt_write_i, addr: mgmt_address_i,
                 wdata: mgmt_writedata_i};

  logic [31:0]                        scratch_reg, scratch_next;
  logic [5:0]                         ctl_reg, ctl_next;
  logic [LANES-1:0]                   loop_reg, loop_next;
  logic [phy_csr_pkg::FLAG_SEL_W-1:0] fsel_reg, fsel_next;
  logic [31:0]                        rdata_reg, rdata_next;
  logic                               rvalid_reg;
  logic [LANES-1:0]                   flag_view;
  logic                               wr_phy;

  assign wr_phy = req.wr && (win_of(req.addr) == phy_csr_pkg::WIN_PHY);

  always_comb begin
    scratch_next = scratch_reg;
    ctl_next     = ctl_reg;
    loop_next    = loop_reg;
    fsel_next    = fsel_reg;
    // Only writable offsets are listed; all others are dropped.
    if (wr_phy) begin
      if (req.addr == phy_csr_pkg::OFS_SCRATCH) begin
        scratch_next = req.wdata;
      end else if (req.addr == phy_csr_pkg::OFS_CONTROL) begin
        ctl_next = req.wdata[5:0] & phy_csr_pkg::CTL_WRITE_MASK;
      end else if (req.addr == phy_csr_pkg::OFS_LOOPBACK) begin
        loop_next = req.wdata[LANES-1:0];
      end else if (req.addr == phy_csr_pkg::OFS_FLAG_SEL) begin
        fsel_next = req.wdata[phy_csr_pkg::FLAG_SEL_W-1:0];
      end
    end
  end

  // Only global reset touches the registers.
  always_ff @(posedge mclk_i) begin
    if (glob_rst) begin
      scratch_reg <= phy_csr_pkg::SCRATCH_RESET;
      ctl_reg     <= phy_csr_pkg::CTL_RESET;
      loop_reg    <= '0;
      fsel_reg    <= phy_csr_pkg::FLAG_SEL_RESET;
    end else begin
      scratch_reg <= scratch_next;
      ctl_reg     <= ctl_next;
      loop_reg    <= loop_next;
      fsel_reg    <= fsel_next;
    end
  end

  // ************************************************************
  // Indirect FIFO flag view
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_flag
      assign flag_view[g] = flags_sync[g*phy_csr_pkg::FLAGS_PER_LANE + fsel_reg];
    end
  endgenerate

  // ************************************************************
  // Read path
  // ************************************************************
  always_comb begin
    rdata_next = 32'h00000000;
    if (req.rd && win_of(req.addr) == phy_csr_pkg::WIN_PHY) begin
      if (req.addr == phy_csr_pkg::OFS_REVISION) begin
        rdata_next = REVISION;
      end else if (req.addr == phy_csr_pkg::OFS_SCRATCH) begin
        rdata_next = scratch_reg;
      end else if (req.addr == phy_csr_pkg::OFS_VARIANT0) begin
        rdata_next = VARIANT0;
      end else if (req.addr == phy_csr_pkg::OFS_VARIANT1) begin
        rdata_next = VARIANT1;
      end else if (req.addr == phy_csr_pkg::OFS_VARIANT2) begin
        rdata_next = VARIANT2;
      end else if (req.addr == phy_csr_pkg::OFS_CONTROL) begin
        rdata_next = {26'h0000000, ctl_reg};
      end else if (req.addr == phy_csr_pkg::OFS_BLOCK_LOCK) begin
        rdata_next = {31'h00000000, &lock_sync};
      end else if (req.addr == phy_csr_pkg::OFS_LOOPBACK) begin
        rdata_next[LANES-1:0] = loop_reg;
      end else if (req.addr == phy_csr_pkg::OFS_FLAG_SEL) begin
        rdata_next = {29'h00000000, fsel_reg};
      end else if (req.addr == phy_csr_pkg::OFS_FLAG_READ) begin
        rdata_next[LANES-1:0] = flag_view;
      end
    end
  end

  // Reads are still answered while the global reset pin is low (but not during rst_i) so the host never hangs.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_reg  <= 32'h00000000;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= req.rd;
    end
  end

  // ************************************************************
  // Reset sequencing and outputs
  // ************************************************************
  logic tx_hold, rx_hold, tx_rst_int, rx_rst_int, tx_rdy, rx_rdy, xrst_reg;

  assign tx_hold = glob_rst | ~rst_pins_sync[1] | ctl_reg[phy_csr_pkg::CTL_SYS_RST]
                 | ctl_reg[phy_csr_pkg::CTL_TX_SOFT];
  assign rx_hold = glob_rst | ~rst_pins_sync[0] | ctl_reg[phy_csr_pkg::CTL_SYS_RST]
                 | ctl_reg[phy_csr_pkg::CTL_RX_SOFT];

  path_reset_seq #(.SETTLE(phy_csr_pkg::SETTLE_CYCLES)) u_tx_seq (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .hold_i      (tx_hold),
    .ok_i        (1'b1),
    .logic_rst_o (tx_rst_int),
    .ready_o     (tx_rdy)
  );

  path_reset_seq #(.SETTLE(phy_csr_pkg::SETTLE_CYCLES)) u_rx_seq (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .hold_i      (rx_hold),
    .ok_i        (&lock_sync),
    .logic_rst_o (rx_rst_int),
    .ready_o     (rx_rdy)
  );

  always_ff @(posedge mclk_i) begin
    if (rst_i) xrst_reg <= 1'b1;
    else xrst_reg <= glob_rst | ctl_reg[phy_csr_pkg::CTL_SYS_RST];
  end

  assign tx_pcs_rst_o         = tx_rst_int;
  assign rx_pcs_rst_o         = rx_rst_int;
  assign tx_lanes_stable_o    = tx_rdy;
  assign rx_pcs_ready_o       = rx_rdy;
  assign xcvr_rst_o           = xrst_reg;
  assign cdr_lock_to_ref_o    = ctl_reg[phy_csr_pkg::CTL_LOCK_REF];
  assign cdr_lock_to_data_o   = ctl_reg[phy_csr_pkg::CTL_LOCK_DATA];
  assign serial_loopback_o    = loop_reg;
  assign rx_block_lock_o      = &lock_sync;
  assign mgmt_readdata_o      = rdata_reg;
  assign mgmt_readdatavalid_o = rvalid_reg;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence s_tx_pin_held;
    (!tx_rst_n_i) [*5];
  endsequence
  property p_tx_sync;
    s_tx_pin_held |-> ##[0:2] tx_pcs_rst_o;
  endproperty
  a_tx_sync: assert property (p_tx_sync) else $error("tx pin reset not applied");

  property p_tx_drop;
    !rst_pins_sync[1] |=> tx_pcs_rst_o && !tx_lanes_stable_o;
  endproperty
  a_tx_drop: assert property (p_tx_drop) else $error("lanes stable in reset");

  property p_rx_drop;
    !rst_pins_sync[0] |=> rx_pcs_rst_o && !rx_pcs_ready_o;
  endproperty
  a_rx_drop: assert property (p_rx_drop) else $error("rx ready in reset");

  property p_glob;
    glob_rst |=> tx_pcs_rst_o && rx_pcs_rst_o && scratch_reg == 32'h00000000;
  endproperty
  a_glob: assert property (p_glob) else $error("global reset incomplete");

  property p_keep;
    !glob_rst && !mgmt_write_i |=> $stable(scratch_reg) && $stable(ctl_reg);
  endproperty
  a_keep: assert property (p_keep) else $error("register changed without write");

  property p_rev;
    mgmt_read_i && mgmt_address_i == phy_csr_pkg::OFS_REVISION
      |=> mgmt_readdatavalid_o && mgmt_readdata_o == REVISION;
  endproperty
  a_rev: assert property (p_rev) else $error("revision readback wrong");

  property p_scratch;
    mgmt_write_i && mgmt_address_i == phy_csr_pkg::OFS_SCRATCH && !glob_rst
      ##1 mgmt_read_i && mgmt_address_i == phy_csr_pkg::OFS_SCRATCH && !mgmt_write_i
      |=> mgmt_readdata_o == $past(mgmt_writedata_i, 2);
  endproperty
  a_scratch: assert property (p_scratch) else $error("scratch readback wrong");

  property p_sysrst;
    ctl_reg[phy_csr_pkg::CTL_SYS_RST] |=> tx_pcs_rst_o && rx_pcs_rst_o && xcvr_rst_o;
  endproperty
  a_sysrst: assert property (p_sysrst) else $error("system reset not applied");

  property p_flag;
    mgmt_read_i && mgmt_address_i == phy_csr_pkg::OFS_FLAG_READ
      |=> mgmt_readdata_o[0] == $past(flag_view[0]);
  endproperty
  a_flag: assert property (p_flag) else $error("flag readout wrong");

endmodule // phy_reset_csr_bank

/* File: sim/mgmt_host.sv */
// Management host model: whole-word reads and writes on the register port.
// Assumes the bench calls its tasks only after the synchronous reset is released.
`timescale 1ns/1ps
module mgmt_host (
  input  wire logic                            mclk_i,
  input  wire logic [phy_csr_pkg::DATA_W-1:0]  rdata_i,
  input  wire logic                            rvalid_i,
  output logic      [phy_csr_pkg::ADDR_W-1:0]  addr_o,
  output logic                                 rd_o,
  output logic                                 wr_o,
  output logic      [phy_csr_pkg::DATA_W-1:0]  wdata_o
);
  // ************************************************************
  // Access tasks
  // ************************************************************
  initial begin
    addr_o = 12'h000;
    rd_o = 1'b0;
    wr_o = 1'b0;
    wdata_o = 32'h00000000;
  end

  // Each access is one full word; released lines are inverted so stale values never help.
  task automatic write_word(input logic [11:0] a, input logic [31:0] d);
    @(negedge mclk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge mclk_i);
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask

  // Write then read of one word on consecutive edges; the read must see the new value.
  task automatic write_read(input logic [11:0] a, input logic [31:0] wd, output logic [31:0] d);
    @(negedge mclk_i);
    addr_o = a;
    wdata_o = wd;
    wr_o = 1'b1;
    @(negedge mclk_i);
    wr_o = 1'b0;
    wdata_o = ~wd;
    rd_o = 1'b1;
    @(negedge mclk_i);
    d = (rvalid_i === 1'b1) ? rdata_i : 32'hXXXXXXXX;
    rd_o = 1'b0;
    addr_o = ~a;
  endtask

  // Read data is taken while the one-cycle valid pulse stands.
  task automatic read_word(input logic [11:0] a, output logic [31:0] d);
    @(negedge mclk_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge mclk_i);
    d = (rvalid_i === 1'b1) ? rdata_i : 32'hXXXXXXXX;
    rd_o = 1'b0;
    addr_o = ~a;
  endtask
endmodule // mgmt_host

/* File: sim/phy_reset_and_csr_bank_test.sv */
// Self-checking bench for the reset handling and physical-layer register bank.
// Assumes the design package is compiled first; inputs change on falling edges.
`timescale 1ns/1ps
module phy_reset_and_csr_bank_test;
  localparam logic [31:0] REV = 32'h00020003; // Arbitrary value.
  localparam logic [31:0] ID [3] = '{32'h00001122, 32'h00003344, 32'h00556677}; // Arbitrary.
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        csr_rst_n_i = 1'b0;
  logic        tx_rst_n_i = 1'b0;
  logic        rx_rst_n_i = 1'b0;
  logic [1:0]  block_lock_i = 2'b11;
  logic [15:0] fifo_flags_i = 16'hC35A;
  logic [11:0] addr;
  logic        rd, wr, valid, tx_rst, rx_rst, xcvr_rst, to_ref, to_data, lock, tx_ok, rx_ok;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  loop;
  int          miscompares = 0;
  int          compares = 0;
  int          cycles = 0;

  always #4 mclk_i = ~mclk_i;

  phy_reset_csr_bank #(.LANES(2), .REVISION(REV), .VARIANT0(ID[0]), .VARIANT1(ID[1]),
    .VARIANT2(ID[2])) phy_reset_csr_bank_i (.mclk_i(mclk_i), .rst_i(rst_i),
    .csr_rst_n_i(csr_rst_n_i), .tx_rst_n_i(tx_rst_n_i), .rx_rst_n_i(rx_rst_n_i),
    .mgmt_address_i(addr), .mgmt_read_i(rd), .mgmt_write_i(wr), .mgmt_writedata_i(wdata),
    .mgmt_readdata_o(rdata), .mgmt_readdatavalid_o(valid), .block_lock_i(block_lock_i),
    .fifo_flags_i(fifo_flags_i), .tx_pcs_rst_o(tx_rst), .rx_pcs_rst_o(rx_rst),
    .xcvr_rst_o(xcvr_rst), .cdr_lock_to_ref_o(to_ref), .cdr_lock_to_data_o(to_data),
    .serial_loopback_o(loop), .rx_block_lock_o(lock), .tx_lanes_stable_o(tx_ok),
    .rx_pcs_ready_o(rx_ok));

  mgmt_host mgmt_host_i (.mclk_i(mclk_i), .rdata_i(rdata), .rvalid_i(valid), .addr_o(addr),
    .rd_o(rd), .wr_o(wr), .wdata_o(wdata));

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic print_verdict();
    $display("Counts: %0d compares, %0d miscompares", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    mgmt_host_i.read_word(a, d);
    check(d, exp, "register read");
  endtask

  // Drives {global, transmit, receive} reset pins and holds them ten cycles.
  task automatic pins(input logic [2:0] v);
    @(negedge mclk_i);
    {csr_rst_n_i, tx_rst_n_i, rx_rst_n_i} = v;
    repeat (10) @(negedge mclk_i);
  endtask

  task automatic wait_ready();
    for (int n = 0; n < 200 && !(tx_ok === 1'b1 && rx_ok === 1'b1); n++) @(negedge mclk_i);
    check({tx_ok, rx_ok}, 32'h3, "ready outputs");
  endtask

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      print_verdict();
    end
  end

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    repeat (10) @(negedge mclk_i);
    rst_i = 1'b0;
    pins(3'b111);
    wait_ready();
    $display("Test reset release finished");
    rd_chk(phy_csr_pkg::OFS_REVISION, REV);
    for (int i = 0; i < 3; i++) rd_chk(12'(phy_csr_pkg::OFS_VARIANT0 + i), ID[i]);
    rd_chk(phy_csr_pkg::OFS_SCRATCH, 32'h00000000);
    mgmt_host_i.write_read(phy_csr_pkg::OFS_SCRATCH, 32'h5A3CF069, d);
    check(d, 32'h5A3CF069, "scratch back to back");
    mgmt_host_i.write_word(phy_csr_pkg::OFS_SCRATCH, 32'hA5C30F96);
    rd_chk(phy_csr_pkg::OFS_SCRATCH, 32'hA5C30F96);
    mgmt_host_i.write_word(phy_csr_pkg::OFS_REVISION, 32'hFFFFFFFF);
    rd_chk(phy_csr_pkg::OFS_REVISION, REV);
    mgmt_host_i.write_word(12'h311, 32'hFFFFFFFF);
    rd_chk(12'h311, 32'h00000000);
    mgmt_host_i.write_word(12'h401, 32'h12345678);
    rd_chk(12'h401, 32'h00000000);
    rd_chk(12'h2FF, 32'h00000000);
    $display("Test register access finished");
    mgmt_host_i.write_word(phy_csr_pkg::OFS_CONTROL, 32'hFFFFFFFF);
    rd_chk(phy_csr_pkg::OFS_CONTROL, 32'h00000037);
    check({xcvr_rst, tx_rst, rx_rst, tx_ok, rx_ok}, 32'h1C, "soft resets");
    check({to_ref, to_data}, 32'h3, "recovery steering");
    rd_chk(phy_csr_pkg::OFS_SCRATCH, 32'hA5C30F96);
    mgmt_host_i.write_word(phy_csr_pkg::OFS_CONTROL, 32'h00000010);
    @(negedge mclk_i);
    check({to_ref, to_data, xcvr_rst}, 32'h4, "reference lock only");
    mgmt_host_i.write_word(phy_csr_pkg::OFS_CONTROL, 32'h00000020);
    @(negedge mclk_i);
    check({to_ref, to_data}, 32'h1, "data lock only");
    wait_ready();
    $display("Test control finished");
    mgmt_host_i.write_word(phy_csr_pkg::OFS_LOOPBACK, 32'hFFFFFFFF);
    check(loop, 32'h3, "loopback lanes");
    mgmt_host_i.write_word(phy_csr_pkg::OFS_LOOPBACK, 32'h00000002);
    check(loop, 32'h2, "loopback lane one");
    rd_chk(phy_csr_pkg::OFS_BLOCK_LOCK, 32'h00000001);
    block_lock_i = 2'b01;
    repeat (8) @(negedge mclk_i);
    check(lock, 32'h0, "block lock output");
    rd_chk(phy_csr_pkg::OFS_BLOCK_LOCK, 32'h00000000);
    block_lock_i = 2'b11;
    for (int c = 0; c < 8; c++) begin
      mgmt_host_i.write_word(phy_csr_pkg::OFS_FLAG_SEL, 32'(c));
      rd_chk(phy_csr_pkg::OFS_FLAG_SEL, 32'(c));
      rd_chk(phy_csr_pkg::OFS_FLAG_READ, {30'h0, fifo_flags_i[8+c], fifo_flags_i[c]});
    end
    $display("Test lanes and flags finished");
    pins(3'b101);
    check({tx_rst, tx_ok, rx_rst}, 32'h4, "transmit pin held");
    pins(3'b111);
    wait_ready();
    pins(3'b110);
    check({rx_rst, rx_ok, tx_rst}, 32'h4, "receive pin held");
    pins(3'b111);
    wait_ready();
    rd_chk(phy_csr_pkg::OFS_SCRATCH, 32'hA5C30F96);
    pins(3'b011);
    check({xcvr_rst, tx_rst, rx_rst, tx_ok, rx_ok}, 32'h1C, "global pin held");
    pins(3'b111);
    wait_ready();
    rd_chk(phy_csr_pkg::OFS_SCRATCH, 32'h00000000);
    rd_chk(phy_csr_pkg::OFS_CONTROL, 32'h00000000);
    $display("Test reset pins finished");
    print_verdict();
  end
endmodule // phy_reset_and_csr_bank_test
